// >>> rtl/tws_sequencer.sv
// Operation
// - Set the continue check flag at the check point of a group when no continue was given.
// - A word end on the tenth word with the check flag set starts the ending delay.
// - At group start a disengaged clutch pulses the clutch error, flags it and starts the delay.
// - Starting the ending delay sets the inhibit-write flag.
// - Expiry of the ending delay gives pulse one, starts the clear delay and drops the modes.
// - The center-drive command drops one stop delay after pulse one.
// - A read ending waits one read-end delay after the last sprocket pulse.
// - The write-clear relay is held for the whole clear delay.
// - Expiry of the clear delay gives pulse two and sets the ten-word flag.
// - Pulse two sets the write gap flag, held for one gap delay.
// - Pulse two sets the circuits-available flag.
// - Expiry of the gap delay gives the gap reset pulse that clears the gap flag.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`default_nettype none
module tws_sequencer #(
    parameter int END_CYC = tws_pkg::END_DELAY_CYC,
    parameter int CLEAR_CYC = tws_pkg::CLEAR_DELAY_CYC,
    parameter int STOP_CYC = tws_pkg::STOP_DELAY_CYC,
    parameter int GAP_CYC = tws_pkg::GAP_DELAY_CYC,
    parameter int READ_END_CYC = tws_pkg::READ_END_DELAY_CYC
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Register port
    input wire logic [tws_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [tws_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [tws_pkg::DATA_W-1:0] o_reg_rdata,
    // Write word timing
    input wire logic i_word_end_pulse,
    input wire logic i_check_point,
    input wire logic i_last_word,
    input wire logic i_group_start,
    // Drive status
    input wire logic i_clutch_disengaged,
    // Read timing
    input wire logic i_read_active,
    input wire logic i_sprocket_pulse,
    // Drive and program outputs
    output logic o_clutch_error_pulse,
    output logic o_ending_pulse_one,
    output logic o_ending_pulse_two,
    output logic o_gap_flag_reset_pulse,
    output logic o_read_end_pulse,
    output logic o_inhibit_write,
    output logic o_write_center_drive,
    output logic o_write_clear_relay,
    output logic o_write_mode,
    output logic o_rw_mode,
    output logic o_write_ready,
    output logic o_continue_check_flag,
    output logic o_ten_word_flag,
    output logic o_write_gap_flag,
    output logic o_circuits_avail,
    output logic o_error_flag
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;
    tws_pkg::tws_seq_t seq_ff;
    tws_pkg::tws_seq_t nxt_seq;
    logic continue_flag_ff;
    logic cont_check_ff;
    logic clutch_err_ff;
    logic error_ff;
    logic inhibit_ff;
    logic write_mode_ff;
    logic rw_mode_ff;
    logic write_ready_ff;
    logic center_drive_ff;
    logic ten_word_ff;
    logic gap_flag_ff;
    logic avail_ff;
    logic relay_ff;
    logic [tws_pkg::DATA_W-1:0] rdata_ff;
    logic wr_status;
    logic wr_control;
    logic cmd_continue;
    logic cmd_write_start;
    logic clutch_hit;
    logic tenth_hit;
    logic end_trigger;
    logic end_active;
    logic ep1;
    logic clear_active;
    logic ep2;
    logic stop_expire;
    logic gap_expire;
    logic read_trigger;
    logic read_expire;
    logic [tws_pkg::DATA_W-1:0] status_word;
    logic [tws_pkg::DATA_W-1:0] control_word;

    // Reset release
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // Register decode
    assign wr_status = i_reg_wr && (i_reg_addr == tws_pkg::REG_STATUS);
    assign wr_control = i_reg_wr && (i_reg_addr == tws_pkg::REG_CONTROL);
    assign cmd_continue = wr_control && i_reg_wdata[tws_pkg::CT_CONTINUE];
    assign cmd_write_start = wr_control && i_reg_wdata[tws_pkg::CT_WRITE_START];

    assign clutch_hit = i_group_start && i_clutch_disengaged && seq_ff != tws_pkg::TWS_CLEAR_WAIT;
    // tenth word end with check set
    assign tenth_hit = i_word_end_pulse && i_last_word && cont_check_ff
        && (seq_ff != tws_pkg::TWS_CLEAR_WAIT);
    assign end_trigger = clutch_hit || tenth_hit;
    assign read_trigger = i_read_active && i_sprocket_pulse;

    tws_delay_timer #(
        .CNT_W(tws_pkg::TIMER_W),
        .COUNT(END_CYC)
    ) u_end_timer (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_trigger(end_trigger),
        .o_active(end_active),
        .o_expire(ep1)
    );

    // clear delay started by pulse one
    tws_delay_timer #(
        .CNT_W(tws_pkg::TIMER_W),
        .COUNT(CLEAR_CYC)
    ) u_clear_timer (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_trigger(ep1),
        .o_active(clear_active),
        .o_expire(ep2)
    );

    tws_delay_timer #(
        .CNT_W(tws_pkg::TIMER_W),
        .COUNT(STOP_CYC)
    ) u_stop_timer (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_trigger(ep1),
        .o_active(),
        .o_expire(stop_expire)
    );

    tws_delay_timer #(
        .CNT_W(tws_pkg::TIMER_W),
        .COUNT(GAP_CYC)
    ) u_gap_timer (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_trigger(ep2),
        .o_active(),
        .o_expire(gap_expire)
    );

    tws_delay_timer #(
        .CNT_W(tws_pkg::TIMER_W),
        .COUNT(READ_END_CYC)
    ) u_read_timer (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_trigger(read_trigger),
        .o_active(),
        .o_expire(read_expire)
    );

    // Sequence state
    always_comb begin
        nxt_seq = seq_ff;
        unique case (seq_ff)
            tws_pkg::TWS_IDLE: begin
                if (end_trigger) begin
                    nxt_seq = tws_pkg::TWS_END_WAIT;
                end
            end
            tws_pkg::TWS_END_WAIT: begin
                if (ep1) begin
                    nxt_seq = tws_pkg::TWS_CLEAR_WAIT;
                end
            end
            tws_pkg::TWS_CLEAR_WAIT: begin
                if (ep2) begin
                    nxt_seq = tws_pkg::TWS_IDLE;
                end
            end
            default: begin
                nxt_seq = tws_pkg::TWS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= tws_pkg::TWS_IDLE;
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    // Continue flag, cleared at group end
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            continue_flag_ff <= tws_pkg::FLAG_RST;
        end else if (cmd_continue) begin
            continue_flag_ff <= 1'b1;
        end else if (i_word_end_pulse && i_last_word) begin
            continue_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cont_check_ff <= tws_pkg::FLAG_RST;
        end else if (i_check_point && !continue_flag_ff && !cmd_continue) begin
            cont_check_ff <= 1'b1;
        end else if ((i_word_end_pulse && i_last_word) || cmd_write_start) begin
            cont_check_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            clutch_err_ff <= 1'b0;
            error_ff <= tws_pkg::FLAG_RST;
        end else begin
            clutch_err_ff <= clutch_hit;
            if (clutch_hit) begin
                error_ff <= 1'b1;
            end else if (wr_status && i_reg_wdata[tws_pkg::ST_ERROR]) begin
                error_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            inhibit_ff <= tws_pkg::FLAG_RST;
        end else if (end_trigger) begin
            inhibit_ff <= 1'b1;
        end else if (cmd_write_start) begin
            inhibit_ff <= 1'b0;
        end
    end

    // pulse one drops modes and ready
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            write_mode_ff <= tws_pkg::FLAG_RST;
            rw_mode_ff <= tws_pkg::FLAG_RST;
            write_ready_ff <= tws_pkg::FLAG_RST;
        end else if (ep1) begin
            write_mode_ff <= 1'b0;
            rw_mode_ff <= 1'b0;
            write_ready_ff <= 1'b0;
        end else if (wr_control) begin
            write_mode_ff <= i_reg_wdata[tws_pkg::CT_WRITE_MODE];
            rw_mode_ff <= i_reg_wdata[tws_pkg::CT_RW_MODE];
            write_ready_ff <= i_reg_wdata[tws_pkg::CT_WRITE_READY];
        end
    end

    // center drive drop after stop delay
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            center_drive_ff <= tws_pkg::FLAG_RST;
        end else if (stop_expire) begin
            center_drive_ff <= 1'b0;
        end else if (cmd_write_start) begin
            center_drive_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            relay_ff <= 1'b0;
        end else begin
            relay_ff <= clear_active;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ten_word_ff <= tws_pkg::FLAG_RST;
        end else if (ep2) begin
            ten_word_ff <= 1'b1;
        end else if (wr_status && i_reg_wdata[tws_pkg::ST_TEN_WORD]) begin
            ten_word_ff <= 1'b0;
        end
    end

    // gap flag set by pulse two
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_flag_ff <= tws_pkg::FLAG_RST;
        end else if (ep2) begin
            gap_flag_ff <= 1'b1;
        end else if (gap_expire) begin
            gap_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            avail_ff <= tws_pkg::AVAIL_RST;
        end else if (ep2) begin
            avail_ff <= 1'b1;
        end else if (cmd_write_start) begin
            avail_ff <= 1'b0;
        end
    end

    // Register read
    always_comb begin
        status_word = '0;
        status_word[tws_pkg::ST_TEN_WORD] = ten_word_ff;
        status_word[tws_pkg::ST_WRITE_GAP] = gap_flag_ff;
        status_word[tws_pkg::ST_AVAIL] = avail_ff;
        status_word[tws_pkg::ST_ERROR] = error_ff;
        status_word[tws_pkg::ST_INHIBIT] = inhibit_ff;
        status_word[tws_pkg::ST_CONT_CHECK] = cont_check_ff;
        status_word[tws_pkg::ST_BUSY] = seq_ff != tws_pkg::TWS_IDLE;
        status_word[tws_pkg::ST_CENTER_DRIVE] = center_drive_ff;
    end

    always_comb begin
        control_word = '0;
        control_word[tws_pkg::CT_CONTINUE] = continue_flag_ff;
        control_word[tws_pkg::CT_WRITE_MODE] = write_mode_ff;
        control_word[tws_pkg::CT_RW_MODE] = rw_mode_ff;
        control_word[tws_pkg::CT_WRITE_READY] = write_ready_ff;
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else if (i_reg_rd && (i_reg_addr == tws_pkg::REG_STATUS)) begin
            rdata_ff <= status_word;
        end else if (i_reg_rd && (i_reg_addr == tws_pkg::REG_CONTROL)) begin
            rdata_ff <= control_word;
        end else begin
            rdata_ff <= '0;
        end
    end

    // Outputs
    assign o_reg_rdata = rdata_ff;
    assign o_clutch_error_pulse = clutch_err_ff;
    assign o_ending_pulse_one = ep1;
    assign o_ending_pulse_two = ep2;
    assign o_gap_flag_reset_pulse = gap_expire;
    assign o_read_end_pulse = read_expire;
    assign o_inhibit_write = inhibit_ff;
    assign o_write_center_drive = center_drive_ff;
    assign o_write_clear_relay = relay_ff;
    assign o_write_mode = write_mode_ff;
    assign o_rw_mode = rw_mode_ff;
    assign o_write_ready = write_ready_ff;
    assign o_continue_check_flag = cont_check_ff;
    assign o_ten_word_flag = ten_word_ff;
    assign o_write_gap_flag = gap_flag_ff;
    assign o_circuits_avail = avail_ff;
    assign o_error_flag = error_ff;
endmodule
`default_nettype wire

// >>> inc/tws_pkg.sv
`default_nettype none
package tws_pkg;
    // Clock rate
    localparam int CLK_FREQ_MHZ = 250;
    // Delay times in microseconds
    localparam int END_DELAY_US = 1500;
    localparam int CLEAR_DELAY_US = 10000;
    localparam int STOP_DELAY_US = 1500;
    localparam int GAP_DELAY_US = 10000;
    localparam int READ_END_DELAY_US = 1500;
    // Delay counts in clock cycles
    localparam int END_DELAY_CYC = END_DELAY_US * CLK_FREQ_MHZ;
    localparam int CLEAR_DELAY_CYC = CLEAR_DELAY_US * CLK_FREQ_MHZ;
    localparam int STOP_DELAY_CYC = STOP_DELAY_US * CLK_FREQ_MHZ;
    localparam int GAP_DELAY_CYC = GAP_DELAY_US * CLK_FREQ_MHZ;
    localparam int READ_END_DELAY_CYC = READ_END_DELAY_US * CLK_FREQ_MHZ;
    localparam int TIMER_W = 22;
    // Register port
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [1:0] REG_STATUS = 2'h0;
    localparam logic [1:0] REG_CONTROL = 2'h1;
    // Status fields
    localparam int ST_TEN_WORD = 0;
    localparam int ST_WRITE_GAP = 1;
    localparam int ST_AVAIL = 2;
    localparam int ST_ERROR = 3;
    localparam int ST_INHIBIT = 4;
    localparam int ST_CONT_CHECK = 5;
    localparam int ST_BUSY = 6;
    localparam int ST_CENTER_DRIVE = 7;
    // Control fields
    localparam int CT_CONTINUE = 0;
    localparam int CT_WRITE_START = 1;
    localparam int CT_WRITE_MODE = 2;
    localparam int CT_RW_MODE = 3;
    localparam int CT_WRITE_READY = 4;
    // Values after reset
    localparam logic AVAIL_RST = 1'b1;
    localparam logic FLAG_RST = 1'b0;
    // Ending sequence states
    typedef enum logic [1:0] {
        TWS_IDLE,
        TWS_END_WAIT,
        TWS_CLEAR_WAIT
    } tws_seq_t;
endpackage
`default_nettype wire

// >>> rtl/tws_delay_timer.sv
`default_nettype none
module tws_delay_timer #(
    parameter int CNT_W = 22,
    parameter int COUNT = 375000
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Trigger and results
    input wire logic i_trigger,
    output logic o_active,
    output logic o_expire
);
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic active_ff;
    logic expire_ff;

    always_comb begin
        nxt_count = count_ff;
        if (i_trigger) begin
            nxt_count = CNT_W'(COUNT);
        end else if (count_ff != '0) begin
            nxt_count = count_ff - CNT_W'(1);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_ff <= '0;
            active_ff <= 1'b0;
            expire_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            active_ff <= nxt_count != '0;
            expire_ff <= !i_trigger && (count_ff == CNT_W'(1));
        end
    end

    assign o_active = active_ff;
    assign o_expire = expire_ff;
endmodule
`default_nettype wire

// >>> test/tws_sequencer_chk.sv
`default_nettype none
module tws_sequencer_chk #(
    parameter int END_CYC = 20,
    parameter int CLEAR_CYC = 40,
    parameter int STOP_CYC = 20,
    parameter int GAP_CYC = 40,
    parameter int READ_END_CYC = 20
) (
    // Clock, reset and inputs
    input wire logic i_mclk, i_resetn, i_word_end_pulse, i_check_point, i_last_word,
    input wire logic i_group_start, i_clutch_disengaged, i_sprocket_pulse,
    // Outputs
    input wire logic o_clutch_error_pulse, o_ending_pulse_one, o_ending_pulse_two,
    input wire logic o_gap_flag_reset_pulse, o_read_end_pulse, o_inhibit_write,
    input wire logic o_write_center_drive, o_write_clear_relay, o_write_mode, o_rw_mode,
    input wire logic o_write_ready, o_continue_check_flag, o_ten_word_flag,
    input wire logic o_write_gap_flag, o_circuits_avail, o_error_flag
);
    localparam int E_LO = END_CYC;
    localparam int E_HI = END_CYC + 2;
    localparam int C_LO = CLEAR_CYC;
    localparam int C_HI = CLEAR_CYC + 2;
    localparam int G_LO = GAP_CYC;
    localparam int G_HI = GAP_CYC + 2;
    localparam int S_DLY = STOP_CYC - 1;
    logic [15:0] relay_cnt_ff;
    logic [15:0] sprk_cnt_ff;
    // Length of each relay pulse
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) relay_cnt_ff <= 16'h0000;
        else if (o_write_clear_relay) relay_cnt_ff <= relay_cnt_ff + 16'h0001;
        else relay_cnt_ff <= 16'h0000;
    end
    // Cycles since the last sprocket
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) sprk_cnt_ff <= 16'h0000;
        else if (i_sprocket_pulse) sprk_cnt_ff <= 16'h0000;
        else if (sprk_cnt_ff != 16'hffff) sprk_cnt_ff <= sprk_cnt_ff + 16'h0001;
    end
    logic clr_busy_ff;
    // Clear delay window, new starts ignored
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) clr_busy_ff <= 1'b0;
        else if (o_ending_pulse_one) clr_busy_ff <= 1'b1;
        else if (o_ending_pulse_two) clr_busy_ff <= 1'b0;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    AST_CONT_CHECK: assert property ($rose(o_continue_check_flag)
        |-> $past(i_check_point)) else $error("continue check set without check point");
    AST_TENTH_INHIBIT: assert property (i_word_end_pulse && i_last_word
        && o_continue_check_flag && !clr_busy_ff |=> o_inhibit_write)
        else $error("tenth word end missed");
    AST_CLUTCH: assert property (i_group_start && i_clutch_disengaged
        && !clr_busy_ff |=> o_clutch_error_pulse && o_error_flag && o_inhibit_write)
        else $error("clutch hit missed");
    AST_EP1: assert property ($rose(o_inhibit_write) |-> ##[E_LO:E_HI] o_ending_pulse_one)
        else $error("ending pulse one late");
    AST_MODES: assert property (o_ending_pulse_one
        |=> !o_write_mode && !o_rw_mode && !o_write_ready) else $error("modes not cleared");
    AST_CENTER: assert property (o_ending_pulse_one |-> ##S_DLY o_write_center_drive
        ##[1:4] !o_write_center_drive) else $error("center drive drop timing");
    AST_READ_END: assert property (o_read_end_pulse
        |-> sprk_cnt_ff >= 16'(READ_END_CYC - 1) && sprk_cnt_ff <= 16'(READ_END_CYC + 2))
        else $error("read end timing");
    AST_RELAY: assert property ($fell(o_write_clear_relay)
        |-> relay_cnt_ff >= 16'(CLEAR_CYC - 1) && relay_cnt_ff <= 16'(CLEAR_CYC + 2))
        else $error("relay length wrong");
    AST_EP2: assert property (o_ending_pulse_one |-> ##[C_LO:C_HI] o_ending_pulse_two)
        else $error("ending pulse two late");
    AST_FLAGS: assert property (o_ending_pulse_two
        |-> $past(o_write_clear_relay) ##1 o_ten_word_flag && o_write_gap_flag
        && o_circuits_avail) else $error("flags not set");
    AST_GAP: assert property (o_ending_pulse_two |-> ##[G_LO:G_HI] o_gap_flag_reset_pulse
        ##1 !o_write_gap_flag) else $error("gap flag not cleared");
    AST_PULSE: assert property (o_ending_pulse_one |=> !o_ending_pulse_one)
        else $error("pulse too long");
    COV_EP1: cover property (o_ending_pulse_one);
    COV_CLUTCH: cover property (o_clutch_error_pulse);
    COV_GAP: cover property (o_gap_flag_reset_pulse);
    COV_READ: cover property (o_read_end_pulse);
endmodule
bind tws_sequencer tws_sequencer_chk #(.END_CYC(END_CYC), .CLEAR_CYC(CLEAR_CYC),
    .STOP_CYC(STOP_CYC), .GAP_CYC(GAP_CYC), .READ_END_CYC(READ_END_CYC)) i_chk (.*);
`default_nettype wire

// >>> test/tws_tape_model.sv
`default_nettype none
module tws_tape_model (
    // Clock, reset, commands
    input wire logic i_clk, i_rst_n, i_go_write, i_go_read, i_clutch_bad,
    // Drive timing
    output logic o_word_end, o_check_point, o_last_word, o_group_start,
    output logic o_clutch_disengaged, o_read_active, o_sprocket, o_done
);
    int mode;
    int cyc;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {o_word_end, o_check_point, o_last_word, o_group_start} <= 4'h0;
            {o_clutch_disengaged, o_read_active, o_sprocket, o_done} <= 4'h0;
            mode <= 0;
            cyc <= 0;
        end else begin
            o_word_end <= 1'b0;
            o_check_point <= 1'b0;
            o_group_start <= 1'b0;
            o_sprocket <= 1'b0;
            cyc <= cyc + 1;
            if (i_go_write) begin
                o_group_start <= 1'b1;
                o_clutch_disengaged <= i_clutch_bad;
                {mode, cyc, o_done} <= {32'd1, 32'd0, 1'b0};
            end else if (i_go_read) begin
                {mode, cyc, o_done, o_read_active} <= {32'd2, 32'd0, 1'b0, 1'b1};
            end else if (mode == 1) begin
                if (cyc % 8 == 7) o_word_end <= 1'b1;
                if (cyc == 72) {o_check_point, o_last_word} <= 2'b11;
                if (cyc == 80) {o_last_word, mode, o_done} <= {1'b0, 32'd0, 1'b1};
            end else if (mode == 2) begin
                if (cyc % 8 == 0 && cyc < 40) o_sprocket <= 1'b1;
                if (cyc == 80) {o_read_active, mode, o_done} <= {1'b0, 32'd0, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, go_w = 1'b0, go_r = 1'b0, bad = 1'b0;
    logic [7:0] rdata;
    logic we, cp, lw, gs, cl, ra, sp, done, clu, ep1, ep2, gr, rde;
    int n_mismatch = 0, n_tests = 0, n_cyc = 0;
    int n_ep1 = 0, n_ep2 = 0, n_gr = 0, n_clu = 0, n_rde = 0;
    always #2 i_mclk = ~i_mclk;
    tws_tape_model i_tws_tape_model (.i_clk(i_mclk), .i_rst_n(i_resetn), .i_go_write(go_w),
        .i_go_read(go_r), .i_clutch_bad(bad), .o_word_end(we), .o_check_point(cp),
        .o_last_word(lw), .o_group_start(gs), .o_clutch_disengaged(cl), .o_read_active(ra),
        .o_sprocket(sp), .o_done(done));
    tws_sequencer #(.END_CYC(20), .CLEAR_CYC(40), .STOP_CYC(20), .GAP_CYC(40),
        .READ_END_CYC(20)) i_tws_sequencer (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_word_end_pulse(we), .i_check_point(cp), .i_last_word(lw),
        .i_group_start(gs), .i_clutch_disengaged(cl), .i_read_active(ra),
        .i_sprocket_pulse(sp), .o_clutch_error_pulse(clu), .o_ending_pulse_one(ep1),
        .o_ending_pulse_two(ep2), .o_gap_flag_reset_pulse(gr), .o_read_end_pulse(rde),
        .o_inhibit_write(), .o_write_center_drive(), .o_write_clear_relay(),
        .o_write_mode(), .o_rw_mode(), .o_write_ready(), .o_continue_check_flag(),
        .o_ten_word_flag(), .o_write_gap_flag(), .o_circuits_avail(), .o_error_flag());
    task automatic stop_test();
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge i_mclk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge i_mclk);
        {addr, rd} <= {a, 1'b1};
        @(posedge i_mclk);
        rd <= 1'b0;
        #1 check(rdata & mask, exp);
    endtask
    task automatic go(input bit read_op);
        @(posedge i_mclk);
        if (read_op) go_r <= 1'b1;
        else go_w <= 1'b1;
        @(posedge i_mclk);
        {go_r, go_w} <= 2'b00;
    endtask
    task automatic wait_done();
        // Skip the done level left by the previous transfer
        @(posedge i_mclk);
        for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge i_mclk);
        if (done !== 1'b1) n_mismatch++;
    endtask
    always @(posedge i_mclk) begin
        n_cyc++;
        if (ep1 === 1'b1) n_ep1++;
        if (ep2 === 1'b1) n_ep2++;
        if (gr === 1'b1) n_gr++;
        if (clu === 1'b1) n_clu++;
        if (rde === 1'b1) n_rde++;
        if (n_cyc > 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        // Reset values and unmapped index
        reg_rd(2'h0, 8'hff, 8'h04);
        reg_rd(2'h1, 8'hff, 8'h00);
        reg_wr(2'h3, 8'hff);
        reg_rd(2'h3, 8'hff, 8'h00);
        // Plain group, no continue
        reg_wr(2'h1, 8'h1e);
        reg_rd(2'h1, 8'hff, 8'h1c);
        reg_rd(2'h0, 8'ha4, 8'h80);
        go(1'b0);
        repeat (75) @(posedge i_mclk);
        reg_rd(2'h0, 8'h20, 8'h20);
        wait_done();
        repeat (70) @(posedge i_mclk);
        reg_rd(2'h1, 8'hff, 8'h00);
        reg_rd(2'h0, 8'h8f, 8'h07);
        repeat (45) @(posedge i_mclk);
        reg_rd(2'h0, 8'h02, 8'h00);
        reg_wr(2'h0, 8'h01);
        reg_rd(2'h0, 8'h01, 8'h00);
        check(8'(n_ep1 + n_ep2 + n_gr), 8'h03);
        // Continue before the check point
        reg_wr(2'h1, 8'h1e);
        go(1'b0);
        repeat (10) @(posedge i_mclk);
        reg_wr(2'h1, 8'h1d);
        wait_done();
        repeat (40) @(posedge i_mclk);
        check(8'(n_ep1), 8'h01);
        reg_rd(2'h1, 8'h1c, 8'h1c);
        // Clutch disengaged at group start
        bad <= 1'b1;
        reg_wr(2'h1, 8'h1e);
        go(1'b0);
        repeat (10) @(posedge i_mclk);
        reg_wr(2'h1, 8'h1d);
        reg_rd(2'h0, 8'h58, 8'h58);
        wait_done();
        repeat (70) @(posedge i_mclk);
        check(8'(n_clu + n_ep2), 8'h03);
        reg_rd(2'h0, 8'h08, 8'h08);
        reg_wr(2'h0, 8'h08);
        reg_rd(2'h0, 8'h08, 8'h00);
        bad <= 1'b0;
        // Read burst with retriggering sprockets
        go(1'b1);
        wait_done();
        check(8'(n_rde), 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
